// ### eif_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - A falling edge on the active-low source-5 pin sets the source-5 flag.
// - A rising edge on the source-4 pin sets the source-4 flag.
// - A falling edge on the active-low source-3 pin sets the source-3 flag.
// - A rising edge on the source-2 pin sets the source-2 flag.
// - Hardware never clears a source flag; software writes zero to clear it.
// - Software writing one to a source flag raises its request if enabled.
// - Reserved bits read fixed: flags bit 3, control bit 6 and enables bits 7 to 5 one, the rest zero.
// - The doubler bit set runs serial port 1 at twice the normal baud rate.
// - The power-fail enable bit gates the power-fail request.
// - A power-fail event on the power-fail pin sets the power-fail flag.
// - A power-fail flag left set keeps raising the power-fail request.
// - Software writing one to the power-fail flag raises the request if enabled.
// - Each source 2 to 5 has an enable bit that gates its request.
module eif_top
  import eif_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // special function register port of the core
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_hit_o,
  // external event pins
  input  wire logic       src5_falling_pin_i,
  input  wire logic       src4_rising_pin_i,
  input  wire logic       src3_falling_pin_i,
  input  wire logic       src2_rising_pin_i,
  input  wire logic       power_fail_pin_i,
  // serial port 1 rate
  input  wire logic       serial1_rate_tick_i,
  output logic            serial1_baud_tick_o,
  output logic            serial1_baud_doubler_o,
  // requests to the core interrupt logic
  output logic      [3:0] src_irq_o,
  output logic            power_fail_irq_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] src_edge_flag;     // index 0 = src2 ... 3 = src5
  logic [NUM_SRC-1:0] src_enable;
  logic               power_fail_flag;
  logic               power_fail_irq_enable;
  logic               serial1_baud_doubler;
  logic               half_rate_phase;

  logic [NUM_SRC-1:0] next_src_edge_flag;
  logic               next_power_fail_flag;

  logic               wr_flags;
  logic               wr_ctrl;
  logic               wr_enables;
  logic [7:0]         ext_irq_flags;
  logic [7:0]         power_fail_and_serial_ctrl;
  logic [7:0]         ext_irq_enables;
  logic [7:0]         read_mux;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detectors
  // ---------------------------------------------------------------
  eif_edge_if #(.N(NUM_PINS)) edges ();

  assign edges.raw = {power_fail_pin_i,
                      src5_falling_pin_i,
                      src4_rising_pin_i,
                      src3_falling_pin_i,
                      src2_rising_pin_i};

  eif_edge_detect #(
    .N       (NUM_PINS),
    .FALLING (FALLING_MASK)
  ) u_edge (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .edges  (edges)
  );

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign wr_flags   = sfr_wr_i && (sfr_addr_i == EXT_IRQ_FLAGS_ADDR);
  assign wr_ctrl    = sfr_wr_i && (sfr_addr_i == POWER_FAIL_SERIAL_ADDR);
  assign wr_enables = sfr_wr_i && (sfr_addr_i == EXT_IRQ_ENABLES_ADDR);

  // combinational so the core can steer its own read mux in the same cycle
  assign sfr_hit_o = (sfr_addr_i == EXT_IRQ_FLAGS_ADDR)
                  || (sfr_addr_i == POWER_FAIL_SERIAL_ADDR)
                  || (sfr_addr_i == EXT_IRQ_ENABLES_ADDR);

  // ---------------------------------------------------------------
  // source flags
  // ---------------------------------------------------------------
  always_comb begin
    next_src_edge_flag = src_edge_flag;
    if (wr_flags) begin
      // writing one sets, as a pin edge would
      next_src_edge_flag = sfr_wdata_i[SRC_FLAG_LSB +: NUM_SRC];
    end
    // set beats a clear in the same cycle
    next_src_edge_flag = next_src_edge_flag | edges.pulse[NUM_SRC-1:0];
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      src_edge_flag <= EXT_IRQ_FLAGS_RESET[SRC_FLAG_LSB +: NUM_SRC];
    end else begin
      src_edge_flag <= next_src_edge_flag;
    end
  end

  // ---------------------------------------------------------------
  // source enables
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      src_enable <= EXT_IRQ_ENABLES_RESET[SRC_ENABLE_LSB +: NUM_SRC];
    end else if (wr_enables) begin
      src_enable <= sfr_wdata_i[SRC_ENABLE_LSB +: NUM_SRC];
    end
  end

  // ---------------------------------------------------------------
  // power fail flag and control bits
  // ---------------------------------------------------------------
  always_comb begin
    next_power_fail_flag = power_fail_flag;
    // software may set the flag directly
    if (wr_ctrl) begin
      next_power_fail_flag = sfr_wdata_i[PF_FLAG_BIT];
    end
    // set beats a clear in the same cycle
    next_power_fail_flag = next_power_fail_flag | edges.pulse[PF_PIN_IDX];
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      power_fail_flag <= POWER_FAIL_SERIAL_RESET[PF_FLAG_BIT];
    end else begin
      power_fail_flag <= next_power_fail_flag;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      power_fail_irq_enable <= POWER_FAIL_SERIAL_RESET[PF_ENABLE_BIT];
      serial1_baud_doubler  <= POWER_FAIL_SERIAL_RESET[BAUD_DOUBLER_BIT];
    end else if (wr_ctrl) begin
      power_fail_irq_enable <= sfr_wdata_i[PF_ENABLE_BIT];
      serial1_baud_doubler  <= sfr_wdata_i[BAUD_DOUBLER_BIT];
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests
  // ---------------------------------------------------------------
  // enable gates each source
  assign src_irq_o = src_edge_flag & src_enable;

  // a flag left set keeps the request up
  assign power_fail_irq_o = power_fail_flag & power_fail_irq_enable;

  // ---------------------------------------------------------------
  // serial port 1 rate
  // ---------------------------------------------------------------
  // normal rate passes every second tick; doubled passes them all
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      half_rate_phase <= 1'b0;
    end else if (serial1_rate_tick_i) begin
      half_rate_phase <= ~half_rate_phase;
    end
  end

  // doubler selects the full tick rate
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      serial1_baud_tick_o <= 1'b0;
    end else begin
      serial1_baud_tick_o <= serial1_rate_tick_i
                           & (serial1_baud_doubler | half_rate_phase);
    end
  end

  assign serial1_baud_doubler_o = serial1_baud_doubler;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // reserved bits read as fixed values
  assign ext_irq_flags = EXT_IRQ_FLAGS_FIXED
                       | {src_edge_flag, 4'h0};

  assign power_fail_and_serial_ctrl = POWER_FAIL_SERIAL_FIXED
                                    | {serial1_baud_doubler, 1'b0,
                                       power_fail_irq_enable, power_fail_flag,
                                       4'h0};

  assign ext_irq_enables = EXT_IRQ_ENABLES_FIXED
                         | {4'h0, src_enable};

  always_comb begin
    case (sfr_addr_i)
      EXT_IRQ_FLAGS_ADDR:     read_mux = ext_irq_flags;
      POWER_FAIL_SERIAL_ADDR: read_mux = power_fail_and_serial_ctrl;
      EXT_IRQ_ENABLES_ADDR:   read_mux = ext_irq_enables;
      default:                read_mux = 8'h00;
    endcase
  end

  // data held until the next read; reads have no side effects
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= read_mux;
    end
  end

endmodule // eif_top

// ### eif_pkg.sv
package eif_pkg;

  // ---------------------------------------------------------------
  // special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] EXT_IRQ_FLAGS_ADDR        = 8'h91;
  localparam logic [7:0] POWER_FAIL_SERIAL_ADDR    = 8'hD8;
  localparam logic [7:0] EXT_IRQ_ENABLES_ADDR      = 8'hE8;

  // ---------------------------------------------------------------
  // reset values (reserved bits included)
  // ---------------------------------------------------------------
  localparam logic [7:0] EXT_IRQ_FLAGS_RESET       = 8'h08;
  localparam logic [7:0] POWER_FAIL_SERIAL_RESET   = 8'h40;
  localparam logic [7:0] EXT_IRQ_ENABLES_RESET     = 8'hE0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SRC_FLAG_LSB        = 4;   // flags of src2..src5 at bits 4..7
  localparam int SRC_ENABLE_LSB      = 0;   // enables of src2..src5 at bits 0..3
  localparam int BAUD_DOUBLER_BIT    = 7;
  localparam int PF_ENABLE_BIT       = 5;
  localparam int PF_FLAG_BIT         = 4;

  // fixed patterns of reserved bits on read
  localparam logic [7:0] EXT_IRQ_FLAGS_FIXED       = 8'h08;
  localparam logic [7:0] POWER_FAIL_SERIAL_FIXED   = 8'h40;
  localparam logic [7:0] EXT_IRQ_ENABLES_FIXED     = 8'hE0;

  // ---------------------------------------------------------------
  // pin handling
  // ---------------------------------------------------------------
  localparam int NUM_SRC             = 4;
  localparam int NUM_PINS            = 5;   // four sources plus power fail
  localparam int PF_PIN_IDX          = 4;
  localparam int SYNC_STAGES         = 2;
  // one marks a pin whose event is a falling edge (src3, src5)
  localparam logic [4:0] FALLING_MASK = 5'h0A;

endpackage

// ### eif_edge_if.sv
`timescale 1ns/1ps
interface eif_edge_if #(
  parameter int N = 5
);
  logic [N-1:0] raw;
  logic [N-1:0] pulse;

  modport detector (input raw, output pulse);
  modport core     (output raw, input pulse);
endinterface

// ### eif_edge_detect.sv
`timescale 1ns/1ps
module eif_edge_detect
  import eif_pkg::*;
#(
  parameter int         N       = NUM_PINS,
  parameter logic [4:0] FALLING = FALLING_MASK
) (
  input  wire logic    mclk_i,
  input  wire logic    srst_i,
  eif_edge_if.detector edges
);

  // ---------------------------------------------------------------
  // per pin synchroniser and edge detector
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic [SYNC_STAGES-1:0] sync;
      logic                   last;

      // flops reset to the idle level so release makes no false edge
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          sync <= {SYNC_STAGES{FALLING[g]}};
          last <= FALLING[g];
        end else begin
          sync <= {sync[SYNC_STAGES-2:0], edges.raw[g]};
          last <= sync[SYNC_STAGES-1];
        end
      end

      assign edges.pulse[g] = FALLING[g] ? (last & ~sync[SYNC_STAGES-1])
                                         : (~last & sync[SYNC_STAGES-1]);
    end
  endgenerate

endmodule // eif_edge_detect

// ### eif_pins_model.sv
`timescale 1ns/1ps
module eif_pins_model (
  input  wire logic       mclk_i,
  input  wire logic [4:0] act_i,
  output logic            src2_rising_pin_o  = 1'b0,
  output logic            src3_falling_pin_o = 1'b1,
  output logic            src4_rising_pin_o  = 1'b0,
  output logic            src5_falling_pin_o = 1'b1,
  output logic            power_fail_pin_o   = 1'b0
);
  // ------------------------------------------------------------
  // pins follow the request one edge late, whole cycles only
  // ------------------------------------------------------------
  // levels held whole cycles
  always @(posedge mclk_i) begin
    src2_rising_pin_o  <= act_i[0];
    src3_falling_pin_o <= !act_i[1];
    src4_rising_pin_o  <= act_i[2];
    src5_falling_pin_o <= !act_i[3];
    power_fail_pin_o   <= act_i[4];
  end
endmodule // eif_pins_model

// ### eif_top_props.sv
`timescale 1ns/1ps
module eif_top_props
  import eif_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       srst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_hit_o,
  input wire logic       src5_falling_pin_i,
  input wire logic       src4_rising_pin_i,
  input wire logic       src3_falling_pin_i,
  input wire logic       src2_rising_pin_i,
  input wire logic       power_fail_pin_i,
  input wire logic       serial1_rate_tick_i,
  input wire logic       serial1_baud_tick_o,
  input wire logic       serial1_baud_doubler_o,
  input wire logic [3:0] src_irq_o,
  input wire logic       power_fail_irq_o
);
  // ------------------------------------------------------------
  // shadows of the enables and the doubler bit, seen from the bus alone
  // ------------------------------------------------------------
  logic [3:0] en_q;
  logic       pfen_q;
  logic       dbl_q;
  wire logic  wr_flags = sfr_wr_i && sfr_addr_i == EXT_IRQ_FLAGS_ADDR;
  wire logic  wr_ctrl  = sfr_wr_i && sfr_addr_i == POWER_FAIL_SERIAL_ADDR;
  always_ff @(posedge mclk_i) begin
    if (srst_i) en_q <= 4'h0;
    else if (sfr_wr_i && sfr_addr_i == EXT_IRQ_ENABLES_ADDR) en_q <= sfr_wdata_i[3:0];
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) {dbl_q, pfen_q} <= 2'b00;
    else if (wr_ctrl) {dbl_q, pfen_q} <= {sfr_wdata_i[7], sfr_wdata_i[5]};
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // no write for two cycles, so nothing can clear a fresh flag
  sequence quiet_s;
    !sfr_wr_i [*2];
  endsequence
  // a write on the edge of the pin change could still drop the enable
  sequence rise2_s;
    $rose(src2_rising_pin_i) && en_q[0] && !sfr_wr_i;
  endsequence
  sequence fall5_s;
    $fell(src5_falling_pin_i) && en_q[3] && !sfr_wr_i;
  endsequence
  sequence pfrise_s;
    $rose(power_fail_pin_i) && pfen_q && !sfr_wr_i;
  endsequence
  src2_edge_a: assert property (rise2_s ##1 quiet_s |=> src_irq_o[0])
    else $error("src2 edge lost");
  src5_edge_a: assert property (fall5_s ##1 quiet_s |=> src_irq_o[3])
    else $error("src5 edge lost");
  pf_edge_a: assert property (pfrise_s ##1 quiet_s |=> power_fail_irq_o)
    else $error("power fail edge lost");
  src_gate_a: assert property (!(|(src_irq_o & ~en_q)))
    else $error("request while disabled");
  pf_gate_a: assert property (power_fail_irq_o |-> pfen_q)
    else $error("power fail request while disabled");
  sw_set_a: assert property (wr_flags |=>
    (~src_irq_o & $past(sfr_wdata_i[7:4]) & $past(en_q)) == 4'h0)
    else $error("written flag gave no request");
  pf_set_a: assert property (wr_ctrl && sfr_wdata_i[5] && sfr_wdata_i[4] |=> power_fail_irq_o)
    else $error("written power fail flag gave no request");
  pf_hold_a: assert property (power_fail_irq_o && !wr_ctrl |=> power_fail_irq_o)
    else $error("power fail request dropped");
  no_hw_clear_a: assert property (!$past(srst_i) &&
    |(~src_irq_o & $past(src_irq_o)) |-> $past(sfr_wr_i))
    else $error("request cleared without a write");
  rd_miss_a: assert property (sfr_rd_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  dbl_tick_a: assert property (serial1_rate_tick_i && dbl_q |=> serial1_baud_tick_o)
    else $error("doubled rate tick missing");
endmodule // eif_top_props
bind eif_top eif_top_props chk_u (.*);

// ### eif_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value %0t: got %h want %h", $time, a, b); end end
module eif_top_bench
  import eif_pkg::*;
;
  logic       mclk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic       sfr_rd_i = 1'b0;
  logic       serial1_rate_tick_i = 1'b0;
  logic [4:0] act = 5'h00;
  logic [7:0] sfr_rdata_o;
  logic [3:0] src_irq_o;
  logic       sfr_hit_o, serial1_baud_tick_o, serial1_baud_doubler_o, power_fail_irq_o;
  wire logic  src2_rising_pin_i, src3_falling_pin_i, src4_rising_pin_i;
  wire logic  src5_falling_pin_i, power_fail_pin_i;
  logic [7:0] m91 = 8'h08, md8 = 8'h40, me8 = 8'hE0;
  int         fail_count = 0, cmp_count = 0, ticks = 0;

  eif_top dut_u (.*);
  eif_pins_model pins_u (.mclk_i(mclk_i), .act_i(act), .src2_rising_pin_o(src2_rising_pin_i),
    .src3_falling_pin_o(src3_falling_pin_i), .src4_rising_pin_o(src4_rising_pin_i),
    .src5_falling_pin_o(src5_falling_pin_i), .power_fail_pin_o(power_fail_pin_i));

  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (serial1_baud_tick_o === 1'b1) ticks++;

  // ------------------------------------------------------------
  // bus tasks, the write keeps a model of the registers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
    if (a == EXT_IRQ_FLAGS_ADDR) m91 = (d & 8'hF0) | 8'h08;
    if (a == POWER_FAIL_SERIAL_ADDR) md8 = (d & 8'hB0) | 8'h40;
    if (a == EXT_IRQ_ENABLES_ADDR) me8 = (d & 8'h0F) | 8'hE0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge mclk_i);
    sfr_rd_i <= 1'b0;
    #1;
    `CHK(sfr_rdata_o, e)
    // address still stands, so the hit flag can be looked at here
    `CHK(sfr_hit_o, a == EXT_IRQ_FLAGS_ADDR || a == POWER_FAIL_SERIAL_ADDR || a == EXT_IRQ_ENABLES_ADDR)
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return a == 8'h91 ? m91 : a == 8'hD8 ? md8 : a == 8'hE8 ? me8 : 8'h00;
  endfunction
  task automatic end_sim;
    $display("mismatches %0d of %0d compares", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_i);
    fail_count++;
    end_sim();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] a;
    void'($urandom(64));
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(8'h91, 8'h08);
    rd(8'hD8, 8'h40);
    rd(8'hE8, 8'hE0);
    rd(8'h3C, 8'h00);
    // normal rate drops every other tick, first one after reset
    for (int k = 0; k < 2; k++) begin
      wr(8'hD8, k ? 8'h80 : 8'h00);
      ticks = 0;
      for (int i = 0; i < 10; i++) begin
        @(posedge mclk_i);
        serial1_rate_tick_i <= 1'b1;
        @(posedge mclk_i);
        serial1_rate_tick_i <= 1'b0;
        repeat ($urandom % 3) @(posedge mclk_i);
      end
      repeat (3) @(posedge mclk_i);
      `CHK(ticks, k ? 10 : 5)
    end
    wr(8'hE8, 8'h0F);
    wr(8'hD8, 8'h20);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_i);
      act[i] <= 1'b1;
      repeat (5) @(posedge mclk_i);
      #1;
      `CHK({power_fail_irq_o, src_irq_o}, 5'h01 << i)
      @(posedge mclk_i);
      act[i] <= 1'b0;
      repeat (5) @(posedge mclk_i);
      rd(i < 4 ? 8'h91 : 8'hD8, i < 4 ? 8'h08 | (8'h10 << i) : 8'h70);
      wr(i < 4 ? 8'h91 : 8'hD8, i < 4 ? 8'h00 : 8'h20);
    end
    // a clear landing with the edge pulse must lose
    @(posedge mclk_i);
    act[2] <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sfr_addr_i <= 8'h91;
    sfr_wdata_i <= 8'h00;
    sfr_wr_i <= 1'b1;
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
    rd(8'h91, 8'h48);
    wr(8'h91, 8'h00);
    for (int n = 0; n < 40; n++) begin
      a = n % 4 == 3 ? 8'($urandom) : n % 4 == 0 ? 8'h91 : n % 4 == 1 ? 8'hD8 : 8'hE8;
      wr(a, 8'($urandom));
      rd(a, exp_rd(a));
      `CHK(src_irq_o, m91[7:4] & me8[3:0])
      `CHK(power_fail_irq_o, md8[5] & md8[4])
      `CHK(serial1_baud_doubler_o, md8[7])
    end
    end_sim();
  end
endmodule // eif_top_bench
